// ---- eeprom_shadow_config_store_tb.sv ----
/*
 * Testbench: controller and store joined by the link, driven over Wishbone.
 * Assumes the package constants and the shortened completion waits below.
 */
`timescale 1ns/100ps
module eeprom_shadow_config_store_tb;
  localparam int OPC = 50;
  logic         clk_i  = 1'b0;
  logic         rst_i  = 1'b1;
  logic [7:0]   wb_adr = 8'h00;
  logic [31:0]  wb_dat = 32'h0000_0000;
  logic         wb_we  = 1'b0;
  logic         wb_stb = 1'b0;
  logic         wb_cyc = 1'b0;
  logic [31:0]  wb_rd;
  logic         wb_ack;
  logic         motor  = 1'b0;
  logic [767:0] cfg;
  logic [191:0] spd;
  logic         busy;
  logic         refused;
  logic [31:0]  seed   = 32'h0000_0018;
  logic [31:0]  last   = 32'h0000_0000;
  logic [31:0]  v      [24];
  logic [31:0]  exp_q  [$];
  logic [31:0]  msk_q  [$];
  logic [31:0]  me;
  logic [31:0]  mm;
  int           errors = 0;
  int           cmp_count = 0;
  int           cycles = 0;
  int           ref_cnt = 0;
  logic [31:0]  cw;
  always #2 clk_i = ~clk_i;
  nvm_link_if lnk ();
  nvm_cfg_device #(.OP_CYCLES(OPC)) i_nvm_cfg_device (.clk_i(clk_i), .rst_i(rst_i),
    .link(lnk), .motor_spinning_i(motor), .cfg_o(cfg), .speed_curve_o(spd),
    .nvm_busy_o(busy), .op_refused_o(refused));
  // Hold must outlast the store's own work, or requests meet a busy store
  nvm_cfg_host #(.WAIT_CYCLES(OPC + 50)) i_nvm_cfg_host (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(4'hF), .wb_we_i(wb_we),
    .wb_stb_i(wb_stb), .wb_cyc_i(wb_cyc), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
    .motor_spinning_i(motor), .link(lnk));
  nvm_cfg_checker i_nvm_cfg_checker (.clk_i(clk_i), .rst_i(rst_i), .req(lnk.req),
    .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .err(lnk.err),
    .rdata(lnk.rdata));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic summarize();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    last = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // A zero mask marks a poll whose data is not compared
  task automatic wbr(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    wb(a, 1'b0, 32'h0000_0000);
  endtask
  task automatic poll(input logic [31:0] m);
    do wbr(nvm_cfg_pkg::CTL_STATUS, 32'h0000_0000, 32'h0000_0000);
    while ((last & m) !== 32'h0000_0000);
  endtask
  task automatic lop(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] es, input logic [31:0] ms);
    wb(nvm_cfg_pkg::CTL_ADDR, 1'b1, {20'h0_0000, a});
    wb(nvm_cfg_pkg::CTL_WDATA, 1'b1, d);
    wb(nvm_cfg_pkg::CTL_GO, 1'b1, {30'h0000_0000, w, 1'b1});
    poll(32'h0000_0001);
    wbr(nvm_cfg_pkg::CTL_STATUS, es, ms);
  endtask
  task automatic lrd(input logic [11:0] a, input logic [31:0] e);
    lop(1'b0, a, 32'h0000_0000, 32'h0000_0000, 32'h0000_0002);
    wbr(nvm_cfg_pkg::CTL_RDATA, e, 32'hFFFF_FFFF);
  endtask
  // ****************************************************************
  // Monitor and timeout
  // ****************************************************************
  always @(posedge clk_i) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0) begin
      me = exp_q.pop_front();
      mm = msk_q.pop_front();
      if (mm != 32'h0000_0000) chk("wb_dat_o", me & mm, wb_rd & mm);
    end
  end
  // Refusal pulses last one cycle, so they are counted as they pass
  always @(posedge clk_i) begin
    if (refused === 1'b1) ref_cnt++;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int g = 0; g < 24; g++) begin
      v[g] = xs();
      lop(1'b1, nvm_cfg_pkg::MIRROR_FIRST + 12'(2 * g), v[g], 0, 2);
    end
    for (int g = 0; g < 24; g++) begin
      chk("cfg_o", v[g], cfg[g*32 +: 32]);
      lrd(nvm_cfg_pkg::MIRROR_FIRST + 12'(2 * g), v[g]);
    end
    for (int g = 0; g < 6; g++) chk("speed_curve_o", v[10+g], spd[g*32 +: 32]);
    $display("test mirror map done");
    lop(1'b0, 12'h081, 32'h0000_0000, 2, 2);
    lop(1'b0, 12'h0B0, 32'h0000_0000, 2, 2);
    lop(1'b1, 12'h07E, xs(), 2, 2);
    cw = xs() & 32'h0FFF_FFFF;
    lop(1'b1, nvm_cfg_pkg::NVM_COMMAND, cw, 0, 2);
    lrd(nvm_cfg_pkg::NVM_COMMAND, cw);
    chk("nvm_busy_o", 32'h0000_0000, {31'h0000_0000, busy});
    $display("test off-map done");
    motor <= 1'b1;
    repeat (4) @(posedge clk_i);
    lop(1'b1, nvm_cfg_pkg::NVM_COMMAND, nvm_cfg_pkg::KEY_COMMIT, 4, 4);
    lop(1'b1, nvm_cfg_pkg::NVM_COMMAND, nvm_cfg_pkg::KEY_LOAD, 4, 4);
    motor <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(nvm_cfg_pkg::CTL_ADDR, 1'b1, {20'h0_0000, nvm_cfg_pkg::NVM_COMMAND});
    wb(nvm_cfg_pkg::CTL_WDATA, 1'b1, nvm_cfg_pkg::KEY_LOAD);
    // Pin rises so the controller passes the key but the store sees the motor
    motor <= 1'b1;
    wb(nvm_cfg_pkg::CTL_GO, 1'b1, 32'h0000_0003);
    poll(32'h0000_0001);
    wbr(nvm_cfg_pkg::CTL_STATUS, 32'h0000_0002, 32'h0000_000E);
    chk("op_refused_o", 32'h0000_0001, ref_cnt);
    motor <= 1'b0;
    repeat (4) @(posedge clk_i);
    $display("test spinning done");
    lop(1'b1, nvm_cfg_pkg::NVM_COMMAND, nvm_cfg_pkg::KEY_COMMIT, 0, 6);
    chk("nvm_busy_o", 32'h0000_0001, {31'h0000_0000, busy});
    wbr(nvm_cfg_pkg::CTL_STATUS, 32'h0000_0008, 32'h0000_0008);
    poll(32'h0000_0008);
    chk("nvm_busy_o", 32'h0000_0000, {31'h0000_0000, busy});
    for (int g = 0; g < 24; g++) lop(1'b1, 12'h080 + 12'(2 * g), ~v[g], 0, 2);
    lop(1'b1, nvm_cfg_pkg::NVM_COMMAND, nvm_cfg_pkg::KEY_LOAD, 0, 2);
    poll(32'h0000_0008);
    for (int g = 0; g < 24; g++) chk("cfg_o", v[g], cfg[g*32 +: 32]);
    lrd(nvm_cfg_pkg::NVM_COMMAND, 32'h0000_0000);
    $display("test commit and load done");
    summarize();
  end
endmodule

// ---- nvm_cfg_checker.sv ----
/*
 * Link checker: properties on the word link between controller and store.
 * Assumes one clock, synchronous reset, and instantiation beside the link.
 */
`timescale 1ns/100ps
module nvm_cfg_checker (
  // Clock and reset
  input logic        clk_i,
  input logic        rst_i,
  // Link signals
  input logic        req,
  input logic        we,
  input logic [11:0] addr,
  input logic [31:0] wdata,
  input logic        ack,
  input logic        err,
  input logic [31:0] rdata
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  logic in_map;
  logic taken;
  assign in_map = !addr[0] && addr >= nvm_cfg_pkg::MIRROR_FIRST && addr <= nvm_cfg_pkg::MIRROR_LAST;
  assign taken  = req && !ack;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************************************
  // Properties
  // ****************************************************************
  AST_ACK_NEXT: assert property (taken |=> ack)
    else $error("link answer not one cycle after request");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("link ack longer than one cycle");
  AST_REQ_HELD: assert property (taken |=> req && $stable(we) && $stable(addr) && $stable(wdata))
    else $error("link request changed before answer");
  AST_REQ_DROP: assert property (ack |=> !req)
    else $error("link request not released after answer");
  AST_ODD_ERR: assert property (taken && addr[0] |=> ack && err)
    else $error("odd address not refused");
  AST_OFF_MAP: assert property (taken && !in_map && addr != nvm_cfg_pkg::NVM_COMMAND |=> err)
    else $error("unmapped address not refused");
  AST_MIRROR_READ: assert property (taken && !we && in_map |=> !err)
    else $error("mirror read refused");
  AST_WRITE_RDATA: assert property (taken && we |=> rdata == 32'h0000_0000)
    else $error("write answer carried data");
  AST_COMMIT_HOLD: assert property (ack && !err && req && we && addr == nvm_cfg_pkg::NVM_COMMAND
      && wdata == nvm_cfg_pkg::KEY_COMMIT |=> (!req) [*8])
    else $error("request issued during commit wait");
endmodule

// ---- nvm_cfg_device.sv ----
/*
 * Configuration store end: mirror registers, command register and a
 * 1024-bit store with row erase and word program/read.
 * Assumes the controller holds a request until it sees the answer.
 */
// The Wishbone slave port was left to the implementer.
// What this block and its controller do
// - Store 1024 bits as 16 rows of 64
// - Erase clears one whole row at once
// - Program and read in 32-bit words
// - Link writes and reads; never an erase command
// - Mirror registers span 0x080 to 0x0AE
// - Commit and load only while motor stopped
// - Commit key copies all mirrors into store
// - Controller waits 100 ms after commit
// - Controller finishes mirror writes before commit
// - Six speed curve mirrors start at 0x094
// - Load key refreshes mirrors; wait 100 ms
// - Each address is 16 bits; words step 2
`timescale 1ns/100ps
module nvm_cfg_device #(
  parameter int OP_CYCLES = nvm_cfg_pkg::OP_CYCLES
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Link to the controller
  nvm_link_if.dev                       link,
  // Motor state pin
  input  wire logic                     motor_spinning_i,
  // Configuration and status towards the motor logic
  output logic [24*32-1:0]              cfg_o,
  output logic [6*32-1:0]               speed_curve_o,
  output logic                          nvm_busy_o,
  output logic                          op_refused_o
);
  localparam int NM = nvm_cfg_pkg::NUM_MIRROR;
  localparam logic [4:0] LAST_W = 5'(NM - 1);
  localparam logic [4:0] SPEED_W = 5'((nvm_cfg_pkg::SPEED_CURVE_CFG_1
                                       - nvm_cfg_pkg::MIRROR_FIRST) / 2);

  typedef enum logic [2:0] {st_idle, st_erase, st_prog, st_load, st_wait} nvm_state_t;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic mirror_hit(input logic [11:0] a);
    mirror_hit = (a >= nvm_cfg_pkg::MIRROR_FIRST) && (a <= nvm_cfg_pkg::MIRROR_LAST)
                 && (a[0] == 1'b0);
  endfunction

  function automatic logic [4:0] mirror_index(input logic [11:0] a);
    logic [11:0] d;
    d = a - nvm_cfg_pkg::MIRROR_FIRST;
    mirror_index = d[5:1];
  endfunction

  logic [31:0] mirror [NM];
  logic [31:0] store  [nvm_cfg_pkg::WORDS];
  logic [31:0] command;
  nvm_state_t  state;
  logic [4:0]  word;
  logic [31:0] wait_cnt;
  logic        spin_meta;
  logic        spin_q;
  logic        ack_q;
  logic        err_q;
  logic [31:0] rdata_q;

  logic        take;
  logic        busy;
  logic        is_cmd;
  logic        hit;
  logic [4:0]  idx;
  logic        is_key;
  logic        start_commit;
  logic        start_load;
  logic        bad;

  assign take   = link.req && !ack_q;
  assign busy   = state != st_idle;
  assign is_cmd = link.addr == nvm_cfg_pkg::NVM_COMMAND;
  assign hit    = mirror_hit(link.addr);
  assign idx    = mirror_index(link.addr);
  assign is_key = (link.wdata == nvm_cfg_pkg::KEY_COMMIT)
                  || (link.wdata == nvm_cfg_pkg::KEY_LOAD);
  assign start_commit = take && link.we && is_cmd && !busy && !spin_q
                        && link.wdata == nvm_cfg_pkg::KEY_COMMIT;
  assign start_load   = take && link.we && is_cmd && !busy && !spin_q
                        && link.wdata == nvm_cfg_pkg::KEY_LOAD;
  // Writes while busy are turned away so the copy sees a stable image
  assign bad = (!hit && !is_cmd) || (link.we && busy)
               || (link.we && is_cmd && is_key && spin_q);

  assign link.ack   = ack_q;
  assign link.err   = err_q;
  assign link.rdata = rdata_q;

  // ****************************************************************
  // Motor state synchroniser
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spin_meta <= 1'b0;
      spin_q    <= 1'b0;
    end else begin
      spin_meta <= motor_spinning_i;
      spin_q    <= spin_meta;
    end
  end

  // ****************************************************************
  // Link answer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= take;
      if (take) begin
        err_q <= bad;
        if (link.we || bad) begin
          rdata_q <= 32'h0000_0000;
        end else if (is_cmd) begin
          rdata_q <= command;
        end else begin
          rdata_q <= mirror[idx];
        end
      end
    end
  end

  // ****************************************************************
  // Command register
  // ****************************************************************
  // Reads back the key while an operation runs, zero once it is done.
  // Any other value is kept but starts nothing: there is no erase key.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      command <= 32'h0000_0000;
    end else if (take && link.we && is_cmd && !bad && !busy) begin
      command <= link.wdata;
    end else if (state == st_wait && wait_cnt == 32'(OP_CYCLES - 1)) begin
      command <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Mirror registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NM; i++) begin
        mirror[i] <= 32'h0000_0000;
      end
    end else if (take && link.we && hit && !busy) begin
      mirror[idx] <= link.wdata;
    end else if (state == st_load) begin
      mirror[word] <= store[word];
    end
  end

  // ****************************************************************
  // Store array
  // ****************************************************************
  // Not reset: the contents must survive a reset of the logic
  always_ff @(posedge clk_i) begin
    if (state == st_erase) begin
      store[{word[4:1], 1'b0}] <= 32'h0000_0000;
      store[{word[4:1], 1'b1}] <= 32'h0000_0000;
    end else if (state == st_prog) begin
      store[word] <= mirror[word];
    end
  end

  // ****************************************************************
  // Operation sequencer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= st_idle;
      word     <= 5'h00;
      wait_cnt <= 32'h0000_0000;
    end else begin
      case (state)
        st_idle: begin
          word     <= 5'h00;
          wait_cnt <= 32'h0000_0000;
          if (start_commit) begin
            state <= st_erase;
          end else if (start_load) begin
            state <= st_load;
          end
        end
        st_erase: begin
          state <= st_prog;
        end
        st_prog: begin
          if (word == LAST_W) begin
            state <= st_wait;
          end else begin
            word  <= word + 5'h01;
            state <= word[0] ? st_erase : st_prog;
          end
        end
        st_load: begin
          if (word == LAST_W) begin
            state <= st_wait;
          end else begin
            word <= word + 5'h01;
          end
        end
        st_wait: begin
          // Busy for the full completion time, as the cell would be
          if (wait_cnt == 32'(OP_CYCLES - 1)) begin
            state <= st_idle;
          end else begin
            wait_cnt <= wait_cnt + 32'h0000_0001;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // ****************************************************************
  // Status outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nvm_busy_o   <= 1'b0;
      op_refused_o <= 1'b0;
    end else begin
      nvm_busy_o   <= busy || start_commit || start_load;
      op_refused_o <= take && link.we && is_cmd && is_key && spin_q;
    end
  end

  generate
    for (genvar g = 0; g < NM; g++) begin : g_cfg
      assign cfg_o[g*32 +: 32] = mirror[g];
    end
    for (genvar s = 0; s < nvm_cfg_pkg::SPEED_REGS; s++) begin : g_speed
      assign speed_curve_o[s*32 +: 32] = mirror[SPEED_W + 5'(s)];
    end
  endgenerate
endmodule

// ---- nvm_cfg_host.sv ----
/*
 * Controller end: takes word requests from software over classic
 * Wishbone and runs them on the link, holding off 100 ms after keys.
 * Assumes the store answers every request with one ack pulse.
 */
`timescale 1ns/100ps
module nvm_cfg_host #(
  parameter int WAIT_CYCLES = nvm_cfg_pkg::OP_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Motor state pin
  input  wire logic        motor_spinning_i,
  // Link to the store
  nvm_link_if.host         link
);
  logic [11:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rdata_reg;
  logic        err_flag;
  logic        refused;
  logic        hold;
  logic        key_pending;
  logic [31:0] hold_cnt;
  logic        spin_meta;
  logic        spin_q;
  logic        req_q;
  logic        we_q;

  logic        wb_take;
  logic        wr;
  logic        go;
  logic        key_now;
  logic        accept;

  assign wb_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr      = wb_take && wb_we_i;
  assign go      = wr && wb_adr_i == nvm_cfg_pkg::CTL_GO && wb_sel_i[0]
                   && wb_dat_i[nvm_cfg_pkg::GO_START];
  assign key_now = wb_dat_i[nvm_cfg_pkg::GO_WRITE]
                   && addr_reg == nvm_cfg_pkg::NVM_COMMAND
                   && (wdata_reg == nvm_cfg_pkg::KEY_COMMIT
                       || wdata_reg == nvm_cfg_pkg::KEY_LOAD);
  // No new request while one runs or while the hold after a key lasts
  assign accept  = go && !req_q && !hold && !(key_now && spin_q);

  assign link.req   = req_q;
  assign link.we    = we_q;
  assign link.addr  = addr_reg;
  assign link.wdata = wdata_reg;

  // ****************************************************************
  // Motor state synchroniser
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spin_meta <= 1'b0;
      spin_q    <= 1'b0;
    end else begin
      spin_meta <= motor_spinning_i;
      spin_q    <= spin_meta;
    end
  end

  // ****************************************************************
  // Wishbone register writes
  // ****************************************************************
  // Address and data are frozen while a request is on the link
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_reg  <= 12'h000;
      wdata_reg <= 32'h0000_0000;
    end else if (wr && !req_q) begin
      if (wb_adr_i == nvm_cfg_pkg::CTL_ADDR && wb_sel_i[0]) begin
        addr_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_adr_i == nvm_cfg_pkg::CTL_ADDR && wb_sel_i[1]) begin
        addr_reg[11:8] <= wb_dat_i[11:8];
      end
      if (wb_adr_i == nvm_cfg_pkg::CTL_WDATA) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            wdata_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
        end
      end
    end
  end

  // ****************************************************************
  // Link request
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q       <= 1'b0;
      we_q        <= 1'b0;
      key_pending <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      err_flag    <= 1'b0;
    end else if (accept) begin
      req_q       <= 1'b1;
      we_q        <= wb_dat_i[nvm_cfg_pkg::GO_WRITE];
      key_pending <= key_now;
      err_flag    <= 1'b0;
    end else if (req_q && link.ack) begin
      req_q    <= 1'b0;
      err_flag <= link.err;
      if (!we_q) begin
        rdata_reg <= link.rdata;
      end
    end
  end

  // ****************************************************************
  // Completion hold after a key
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold     <= 1'b0;
      hold_cnt <= 32'h0000_0000;
    end else if (req_q && link.ack && key_pending && !link.err) begin
      hold     <= 1'b1;
      hold_cnt <= 32'h0000_0000;
    end else if (hold) begin
      if (hold_cnt == 32'(WAIT_CYCLES - 1)) begin
        hold <= 1'b0;
      end else begin
        hold_cnt <= hold_cnt + 32'h0000_0001;
      end
    end
  end

  // Sticky; a refusal in the same cycle as a clear wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refused <= 1'b0;
    end else if (go && !accept) begin
      refused <= 1'b1;
    end else if (accept) begin
      refused <= 1'b0;
    end
  end

  // ****************************************************************
  // Wishbone answer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_take;
      if (wb_take) begin
        case (wb_adr_i)
          nvm_cfg_pkg::CTL_ADDR:   wb_dat_o <= {20'h0_0000, addr_reg};
          nvm_cfg_pkg::CTL_WDATA:  wb_dat_o <= wdata_reg;
          nvm_cfg_pkg::CTL_STATUS: wb_dat_o <= {28'h000_0000, hold, refused, err_flag, req_q};
          nvm_cfg_pkg::CTL_RDATA:  wb_dat_o <= rdata_reg;
          default:                 wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ---- nvm_cfg_pkg.sv ----
/*
 * Shared constants for the configuration store link: register map,
 * command keys, store geometry and the completion wait.
 * Assumes a 250 MHz system clock on both ends.
 */
package nvm_cfg_pkg;
  // ****************************************************************
  // Store geometry
  // ****************************************************************
  localparam int ROWS        = 16;
  localparam int ROW_BITS    = 64;
  localparam int WORD_BITS   = 32;
  localparam int WORDS       = ROWS * ROW_BITS / WORD_BITS;
  localparam int NUM_MIRROR  = 24;
  localparam int SPEED_REGS  = 6;
  localparam int ADDR_BITS   = 12;
  localparam int ADDR_STEP   = 2;
  // ****************************************************************
  // Link address map (16-bit locations)
  // ****************************************************************
  localparam logic [11:0] RESYNC_REVERSE_DRIVE_CFG = 12'h080;
  localparam logic [11:0] REVERSE_DRIVE_BRAKE_CFG  = 12'h082;
  localparam logic [11:0] STARTUP_CFG_A            = 12'h084;
  localparam logic [11:0] STARTUP_CFG_B            = 12'h086;
  localparam logic [11:0] CONTROL_LOOP_CFG_A       = 12'h088;
  localparam logic [11:0] CONTROL_LOOP_CFG_B       = 12'h08A;
  localparam logic [11:0] CONTROL_LOOP_CFG_C       = 12'h08C;
  localparam logic [11:0] CONTROL_LOOP_CFG_D       = 12'h08E;
  localparam logic [11:0] PROTECTION_CFG_A         = 12'h090;
  localparam logic [11:0] PROTECTION_CFG_B         = 12'h092;
  localparam logic [11:0] SPEED_CURVE_CFG_1        = 12'h094;
  localparam logic [11:0] SPEED_CURVE_CFG_6        = 12'h09E;
  localparam logic [11:0] MISC_ALGORITHM_CFG_A     = 12'h0A0;
  localparam logic [11:0] MISC_ALGORITHM_CFG_B     = 12'h0A2;
  localparam logic [11:0] PIN_FUNCTION_CFG         = 12'h0A4;
  localparam logic [11:0] CHIP_CFG_A               = 12'h0A6;
  localparam logic [11:0] CHIP_CFG_B               = 12'h0A8;
  localparam logic [11:0] PERIPHERAL_CFG           = 12'h0AA;
  localparam logic [11:0] GATE_DRIVE_CFG_A         = 12'h0AC;
  localparam logic [11:0] GATE_DRIVE_CFG_B         = 12'h0AE;
  localparam logic [11:0] MIRROR_FIRST             = RESYNC_REVERSE_DRIVE_CFG;
  localparam logic [11:0] MIRROR_LAST              = GATE_DRIVE_CFG_B;
  localparam logic [11:0] NVM_COMMAND              = 12'h0EA;
  // ****************************************************************
  // Command keys
  // ****************************************************************
  localparam logic [31:0] KEY_COMMIT = 32'h8A50_0000;
  localparam logic [31:0] KEY_LOAD   = 32'h4000_0000;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ      = 250;
  localparam int OP_TIME_MS   = 100;
  localparam int OP_CYCLES    = OP_TIME_MS * 1000 * CLK_MHZ;
  // ****************************************************************
  // Controller Wishbone map (byte addresses) and fields
  // ****************************************************************
  localparam logic [7:0] CTL_ADDR   = 8'h00;
  localparam logic [7:0] CTL_WDATA  = 8'h04;
  localparam logic [7:0] CTL_GO     = 8'h08;
  localparam logic [7:0] CTL_STATUS = 8'h0C;
  localparam logic [7:0] CTL_RDATA  = 8'h10;
  localparam int GO_START    = 0;
  localparam int GO_WRITE    = 1;
  localparam int ST_BUSY     = 0;
  localparam int ST_ERR      = 1;
  localparam int ST_REFUSED  = 2;
  localparam int ST_HOLD     = 3;
endpackage

// ---- nvm_link_if.sv ----
/*
 * Word link between the configuration store and its controller.
 * Assumes one shared clock; request is a level, answer a pulse.
 */
`timescale 1ns/100ps
interface nvm_link_if;
  logic        req;
  logic        we;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic        ack;
  logic        err;
  logic [31:0] rdata;

  modport dev (input req, we, addr, wdata, output ack, err, rdata);
  modport host (output req, we, addr, wdata, input ack, err, rdata);
endinterface
